// ---- rtl/tms_status_ctrl.sv ----
// timer module status/control with counter, wishbone slave and interrupt
//
// Chosen here: the Wishbone register port and the register addresses.
`include "tms_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tms_status_ctrl #(
    parameter int  CW         = `TMS_CNT_WIDTH,
    parameter bit  HAS_PLL_EN = 1'b0
) (
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [3:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          ext_clk_pin,
    input  wire logic          fixed_clk_tick,
    output logic               count_down,
    output logic               center_mode,
    output logic               cnt_enable,
    output logic               overflow_evt,
    output logic               coherency_rst,
    output logic               irq
);
    logic            ovf_q, oie_q, cpwm_q;
    tms_pkg::tms_clk_t clk_q;
    logic [2:0]      ps_q;
    logic            armed_q;
    logic [CW-1:0]   mod_q, cnt_q;
    logic            dir_dn_q;
    logic            ext_s1_q, ext_s2_q, ext_s3_q;
    logic            irq_st_q, irq_mask_q;
    logic            src_tick, cnt_tick, wrap;
    logic            req, wr, rd;
    tms_pkg::tms_sc_t sc_view;
    // -----------------------------------------
    // bus decode
    // -----------------------------------------
    // one-cycle answer: ack the cycle after stb, drop it the next
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;
    assign rd  = req && !wb_we_i;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end
    assign sc_view = '{ovf: ovf_q, oie: oie_q, cpwm: cpwm_q, clk: clk_q, ps: ps_q};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            unique case (wb_adr_i)
                `TMS_ADDR_SC:    wb_dat_o <= {24'h0, sc_view};
                `TMS_ADDR_MOD:   wb_dat_o <= 32'(mod_q);
                `TMS_ADDR_CNT:   wb_dat_o <= 32'(cnt_q);
                `TMS_ADDR_IRQST: wb_dat_o <= {30'h0, irq_mask_q, irq_st_q};
                default:         wb_dat_o <= 32'h0;
            endcase
        end
    end
    // -----------------------------------------
    // control bits
    // -----------------------------------------
    // one register set drives the single counter of the module
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oie_q  <= 1'b0;
            cpwm_q <= 1'b0;
            clk_q  <= tms_pkg::TMS_CLK_OFF;
            ps_q   <= 3'h0;
        end else if (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) begin
            oie_q  <= wb_dat_i[`TMS_BIT_OIE];
            cpwm_q <= wb_dat_i[`TMS_BIT_CPWM];
            clk_q  <= tms_pkg::tms_clk_t'(wb_dat_i[`TMS_CLK_HI:`TMS_CLK_LO]);
            ps_q   <= wb_dat_i[`TMS_PS_HI:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mod_q <= `TMS_MOD_RESET;
        end else if (wr && wb_adr_i == `TMS_ADDR_MOD && &wb_sel_i[1:0]) begin
            mod_q <= wb_dat_i[CW-1:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            coherency_rst <= 1'b0;
        end else begin
            coherency_rst <= wr && wb_adr_i == `TMS_ADDR_SC;
        end
    end
    // -----------------------------------------
    // clock source
    // -----------------------------------------
    // external input is slow (quarter bus rate at most), so a rising-edge tick suffices
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    always_comb begin
        unique case (clk_q)
            tms_pkg::TMS_CLK_OFF:   src_tick = 1'b0;
            tms_pkg::TMS_CLK_BUS:   src_tick = 1'b1;
            tms_pkg::TMS_CLK_FIXED: src_tick = HAS_PLL_EN ? fixed_clk_tick : 1'b1;
            tms_pkg::TMS_CLK_EXT:   src_tick = ext_s2_q && !ext_s3_q;
        endcase
    end
    tms_prescaler #(.PS_W(3)) u_presc (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .src_tick (src_tick),
        .ps       (ps_q),
        .cnt_tick (cnt_tick)
    );
    // -----------------------------------------
    // counter
    // -----------------------------------------
    // in up/down mode the overflow is taken at the turn at the bottom, as the down count steps from 1 to zero
    always_comb begin
        if (cpwm_q) begin
            wrap = cnt_tick && dir_dn_q && cnt_q == CW'(1);
        end else if (mod_q == '0) begin
            wrap = cnt_tick && (&cnt_q);
        end else begin
            wrap = cnt_tick && cnt_q == mod_q;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q    <= '0;
            dir_dn_q <= 1'b0;
        end else if (wr && wb_adr_i == `TMS_ADDR_CNT) begin
            cnt_q    <= '0;
            dir_dn_q <= 1'b0;
        end else if (!cpwm_q) begin
            // direction drops with the mode bit even while the clock is off
            dir_dn_q <= 1'b0;
            if (cnt_tick) begin
                cnt_q <= wrap ? '0 : cnt_q + CW'(1);
            end
        end else if (cnt_tick) begin
            if (dir_dn_q) begin
                cnt_q    <= cnt_q - CW'(1);
                dir_dn_q <= !(cnt_q == CW'(1));
            end else begin
                cnt_q    <= cnt_q + CW'(1);
                dir_dn_q <= (cnt_q + CW'(1)) == mod_q;
            end
        end
    end
    // -----------------------------------------
    // overflow flag
    // -----------------------------------------
    // a new wrap disarms the pending clear so a fresh event is never lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovf_q   <= 1'b0;
            armed_q <= 1'b0;
        end else if (wrap) begin
            ovf_q   <= 1'b1;
            armed_q <= 1'b0;
        end else if (rd && wb_adr_i == `TMS_ADDR_SC && ovf_q) begin
            armed_q <= 1'b1;
        end else if (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) begin
            if (armed_q && !wb_dat_i[`TMS_BIT_OVF]) begin
                ovf_q <= 1'b0;
            end
            armed_q <= 1'b0;
        end
    end
    // -----------------------------------------
    // outputs and interrupt
    // -----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_down   <= 1'b0;
            center_mode  <= 1'b0;
            cnt_enable   <= 1'b0;
            overflow_evt <= 1'b0;
        end else begin
            count_down   <= dir_dn_q;
            center_mode  <= cpwm_q;
            cnt_enable   <= cnt_tick;
            overflow_evt <= wrap;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_st_q   <= 1'b0;
            irq_mask_q <= 1'b0;
        end else begin
            if (wrap) begin
                irq_st_q <= 1'b1;
            end else if (rd && wb_adr_i == `TMS_ADDR_IRQST) begin
                irq_st_q <= 1'b0;
            end
            if (wr && wb_adr_i == `TMS_ADDR_IRQST && wb_sel_i[0]) begin
                irq_mask_q <= wb_dat_i[1];
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= (oie_q && ovf_q) || (irq_mask_q && irq_st_q);
        end
    end
    // -----------------------------------------
    // check helpers
    // -----------------------------------------
    // cycles since the last counter tick; steady means no control write since then
    logic [7:0]      gap_q;
    logic            steady_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_q    <= 8'h00;
            steady_q <= 1'b0;
        end else begin
            if (cnt_tick) begin
                gap_q <= 8'h00;
            end else if (gap_q != 8'hFF) begin
                gap_q <= gap_q + 8'h01;
            end
            // a write may change the source or divider, so the next gap is not judged
            if (wr && wb_adr_i == `TMS_ADDR_SC) begin
                steady_q <= 1'b0;
            end else if (cnt_tick) begin
                steady_q <= 1'b1;
            end
        end
    end
    // -----------------------------------------
    // assertions
    // -----------------------------------------
    AST_OVF_SET: assert property (@(posedge ref_clk) disable iff (srst)
        wrap |=> ovf_q) else $error("flag not set on wrap");
    AST_CLR_NEEDS_READ: assert property (@(posedge ref_clk) disable iff (srst)
        ($fell(ovf_q)) |-> $past(armed_q)) else $error("flag cleared without read");
    AST_RACE_KEEP: assert property (@(posedge ref_clk) disable iff (srst)
        (wrap && ovf_q) |=> ovf_q ##1 ovf_q || wrap) else $error("race lost flag");
    AST_W1_NOEFFECT: assert property (@(posedge ref_clk) disable iff (srst)
        (ovf_q && !wrap && wr && wb_adr_i == `TMS_ADDR_SC && wb_dat_i[7]) |=> ovf_q)
        else $error("write one changed flag");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (srst)
        (oie_q && ovf_q) |=> irq) else $error("irq missing");
    AST_UP_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
        !cpwm_q |=> !dir_dn_q || $past(cpwm_q)) else $error("down count in up mode");
    AST_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        clk_q == tms_pkg::TMS_CLK_OFF |-> !cnt_tick) else $error("counter ran while off");
    AST_COHERENCY: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC) |=> coherency_rst) else $error("no coherency reset");
    AST_ACK: assert property (@(posedge ref_clk) disable iff (srst)
        req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
    COV_WRAP: cover property (@(posedge ref_clk) wrap);
    COV_CLEAR: cover property (@(posedge ref_clk) $fell(ovf_q));
    COV_CENTER: cover property (@(posedge ref_clk) cpwm_q && wrap);
    COV_RACE: cover property (@(posedge ref_clk) armed_q && wrap);
    // -----------------------------------------
    // clocking and counter checks
    // -----------------------------------------
    // gap check is only judged once a full period ran on unchanged settings
    AST_PS_DIV: assert property (@(posedge ref_clk) disable iff (srst)
        (cnt_tick && steady_q && clk_q == tms_pkg::TMS_CLK_BUS)
        |-> gap_q == 8'((1 << ps_q) - 1))
        else $error("prescale period wrong");
    AST_PS_WR: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) |=> ps_q == $past(wb_dat_i[2:0]))
        else $error("prescale field not taken");
    AST_CLK_WR: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) |=> 2'(clk_q) == $past(wb_dat_i[4:3]))
        else $error("clock field not taken");
    AST_FIXED_BUS: assert property (@(posedge ref_clk) disable iff (srst)
        (!HAS_PLL_EN && clk_q == tms_pkg::TMS_CLK_FIXED) |-> src_tick)
        else $error("fixed clock differs from bus clock");
    AST_EXT_SYNC: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_q == tms_pkg::TMS_CLK_EXT && src_tick)
        |-> $past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3))
        else $error("external tick not from a synchronised edge");
    AST_NO_TICK_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        (!cnt_tick && !(wr && wb_adr_i == `TMS_ADDR_CNT)) |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    AST_CNT_CLR: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_CNT) |=> cnt_q == '0)
        else $error("counter write did not clear");
    AST_WRAP_ZERO: assert property (@(posedge ref_clk) disable iff (srst)
        wrap |=> cnt_q == '0)
        else $error("counter not zero after wrap");
    AST_DN_TURN: assert property (@(posedge ref_clk) disable iff (srst)
        (cnt_tick && cpwm_q && !dir_dn_q && (cnt_q + CW'(1)) == mod_q
            && !(wr && wb_adr_i == `TMS_ADDR_CNT)) |=> dir_dn_q)
        else $error("no turn at modulo");
    AST_CPWM_WR: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) |=> cpwm_q == $past(wb_dat_i[5]))
        else $error("centre select not taken");
    AST_CENTER_OUT: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> center_mode == $past(cpwm_q))
        else $error("centre output not following select");
    // -----------------------------------------
    // flag, interrupt and bus checks
    // -----------------------------------------
    AST_OVF_EVT: assert property (@(posedge ref_clk) disable iff (srst)
        wrap |=> overflow_evt)
        else $error("overflow event missing");
    AST_ARM: assert property (@(posedge ref_clk) disable iff (srst)
        (rd && wb_adr_i == `TMS_ADDR_SC && ovf_q && !wrap) |=> armed_q)
        else $error("read did not arm clear");
    AST_CLR_DONE: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0] && armed_q && !wb_dat_i[7] && !wrap)
        |=> !ovf_q)
        else $error("armed clear did not clear");
    AST_OIE_WR: assert property (@(posedge ref_clk) disable iff (srst)
        (wr && wb_adr_i == `TMS_ADDR_SC && wb_sel_i[0]) |=> oie_q == $past(wb_dat_i[6]))
        else $error("enable bit not taken");
    AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        (!oie_q && !(irq_mask_q && irq_st_q)) |=> !irq)
        else $error("irq without enabled source");
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (srst)
        wrap |=> irq_st_q)
        else $error("sticky event not set");
    AST_IRQST_CLR: assert property (@(posedge ref_clk) disable iff (srst)
        (rd && wb_adr_i == `TMS_ADDR_IRQST && !wrap) |=> !irq_st_q)
        else $error("sticky event not cleared by read");
    AST_COH_PULSE: assert property (@(posedge ref_clk) disable iff (srst)
        coherency_rst |-> $past(wr && wb_adr_i == `TMS_ADDR_SC))
        else $error("coherency pulse without write");
    AST_ACK_ONLY_REQ: assert property (@(posedge ref_clk) disable iff (srst)
        wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_READ_SC: assert property (@(posedge ref_clk) disable iff (srst)
        (rd && wb_adr_i == `TMS_ADDR_SC) |=> wb_dat_o[7:0] == 8'($past(sc_view)))
        else $error("status read data wrong");
endmodule : tms_status_ctrl
`default_nettype wire

// ---- rtl/tms_defs.svh ----
// constants of the timer module status/control block
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH
`define TMS_ADDR_SC      4'h0
`define TMS_ADDR_MOD     4'h4
`define TMS_ADDR_CNT     4'h8
`define TMS_ADDR_IRQST   4'hC
`define TMS_BIT_OVF      7
`define TMS_BIT_OIE      6
`define TMS_BIT_CPWM     5
`define TMS_CLK_HI       4
`define TMS_CLK_LO       3
`define TMS_PS_HI        2
`define TMS_SC_RESET     8'h00
`define TMS_MOD_RESET    16'h0000
`define TMS_CNT_WIDTH    16
`endif

// ---- rtl/tms_pkg.sv ----
// types of the timer module status/control block
package tms_pkg;
    typedef enum logic [1:0] {
        TMS_CLK_OFF,
        TMS_CLK_BUS,
        TMS_CLK_FIXED,
        TMS_CLK_EXT
    } tms_clk_t;
    typedef struct packed {
        logic       ovf;
        logic       oie;
        logic       cpwm;
        tms_clk_t   clk;
        logic [2:0] ps;
    } tms_sc_t;
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tms_wb_req_t;
endpackage : tms_pkg

// ---- rtl/tms_prescaler.sv ----
// power-of-two prescaler after source select
`timescale 1ns/1ps
`default_nettype none
module tms_prescaler #(
    parameter int PS_W = 3
) (
    input  wire logic            ref_clk,
    input  wire logic            srst,
    input  wire logic            src_tick,
    input  wire logic [PS_W-1:0] ps,
    output logic                 cnt_tick
);
    localparam int DW = (1 << PS_W) - 1;
    logic [DW-1:0] div_q;
    logic [DW-1:0] mask;
    // -----------------------------------------
    // divider
    // -----------------------------------------
    // mask is taken from the live field, so a new code acts on the next clock
    assign mask = DW'((1 << ps) - 1);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_q <= '0;
        end else if (src_tick) begin
            div_q <= (div_q & mask) == mask ? '0 : div_q + DW'(1);
        end
    end
    assign cnt_tick = src_tick && ((div_q & mask) == mask);
endmodule : tms_prescaler
`default_nettype wire

// ---- test/timer_module_status_control_test.sv ----
// self-checking bench of the timer module status/control block
`timescale 1ns/1ps
`default_nettype none
module timer_module_status_control_test;
    // ----------------
    // signals
    // ----------------
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [3:0]  adr     = 4'h0;
    logic [31:0] wdat    = 32'h0;
    logic        ext_clk = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        count_down;
    logic        center_mode;
    logic        cnt_enable;
    logic        overflow_evt;
    logic        coherency_rst;
    logic        irq;
    logic [31:0] rd;
    logic        dn_seen = 1'b0;
    logic        coh_seen = 1'b0;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          ticks = 0;
    int          ovfs = 0;

    tms_status_ctrl tms_status_ctrl_i (
        .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_clk_pin(ext_clk), .fixed_clk_tick(1'b0), .count_down(count_down),
        .center_mode(center_mode), .cnt_enable(cnt_enable), .overflow_evt(overflow_evt),
        .coherency_rst(coherency_rst), .irq(irq)
    );

    always #5 ref_clk = ~ref_clk;

    // ----------------
    // monitors and watchdog
    // ----------------
    // external source is slow on purpose: one rising edge every 8 bus cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles % 4 == 0) ext_clk <= ~ext_clk;
        if (cnt_enable === 1'b1) ticks++;
        if (overflow_evt === 1'b1) ovfs++;
        if (count_down === 1'b1) dn_seen = 1'b1;
        if (coherency_rst === 1'b1) coh_seen = 1'b1;
        if (cycles == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] %0t got %0h exp %0h..%0h", $time, got, lo, hi);
        end
    endtask : chk_rng

    // classic cycle: request held until the rising edge that samples ack high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic run(input int n, input logic [7:0] sc);
        wb(1'b1, 4'h0, {24'h0, sc});
        ticks = 0;
        ovfs = 0;
        repeat (n) @(posedge ref_clk);
    endtask : run

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 4'h1, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 4'h4, 32'h3);
        wb(1'b1, 4'h8, 32'h0);
        coh_seen = 1'b0;
        run(400, 8'h00);
        chk_rng(ticks, 0, 0);
        chk({31'h0, coh_seen}, 32'h1);
        for (int p = 0; p < 8; p++) begin
            run(1024, {5'h01, p[2:0]});
            chk_rng(ticks, (1024 >> p) - 2, (1024 >> p) + 1);
        end
        run(400, 8'h08);
        chk_rng(ovfs, 98, 101);
        chk({31'h0, center_mode}, 32'h0);
        run(400, 8'h10);
        chk_rng(ticks, 398, 401);
        run(800, 8'h18);
        chk_rng(ticks, 97, 101);
        dn_seen = 1'b0;
        run(600, 8'h28);
        chk({31'h0, center_mode}, 32'h1);
        chk({31'h0, dn_seen}, 32'h1);
        chk_rng(ovfs, 98, 101);
        // stopped clock so no wrap can race the clearing steps
        wb(1'b1, 4'h0, 32'h80);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h80);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        run(10, 8'h48);
        chk({31'h0, irq}, 32'h1);
        run(3, 8'h08);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        repeat (8) @(posedge ref_clk);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        chk({31'h0, rd[7]}, 32'h1);
        wb(1'b1, 4'hC, 32'h2);
        run(10, 8'h08);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h3);
        wb(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule : timer_module_status_control_test
`default_nettype wire
